// ### design/alpc_config.sv
`default_nettype none
module alpc_config
    import alpc_pkg::*;
#(
    parameter int unsigned CNT_W = 16
) (
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic ce_i,
    // register port
    input wire logic [7:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [7:0] rdata_o,
    // mode and switch straps (pins)
    input wire logic link_mode_i,
    input wire logic [1:0] sw_clen_i,
    input wire logic [15:0] sw_baud_i,
    input wire logic [2:0] sw_parity_i,
    // events from the line logic, same clock
    input wire logic nak_rx_i,
    input wire logic rx_valid_i,
    input wire logic [7:0] rx_char_i,
    // settings out
    output logic [7:0] hs1_o,
    output logic [7:0] hs2_o,
    output logic [3:0] data_bits_o,
    output logic [1:0] stop_o,
    output logic [2:0] parity_o,
    output logic parity_check_o,
    output logic eol_o
);
    initial begin
        if (CNT_W < 1 || CNT_W > 8 * 4) begin
            $error("alpc_config: CNT_W out of range");
        end
    end

    // ======================================================================
    // pin synchronisers: straps and mode come from outside the clock domain
    logic link_s1_reg, link_s2_reg;
    logic [1:0] clen_s1_reg, clen_s2_reg;
    logic [15:0] baud_s1_reg, baud_s2_reg;
    logic [2:0] par_s1_reg, par_s2_reg;
    always_ff @(posedge clk_sys_i) begin
        if (ce_i) begin
            link_s1_reg <= link_mode_i;
            link_s2_reg <= link_s1_reg;
            clen_s1_reg <= sw_clen_i;
            clen_s2_reg <= clen_s1_reg;
            baud_s1_reg <= sw_baud_i;
            baud_s2_reg <= baud_s1_reg;
            par_s1_reg <= sw_parity_i;
            par_s2_reg <= par_s1_reg;
        end
    end

    // ======================================================================
    // decode helpers
    function automatic logic [1:0] alpc_clip_len(input logic [7:0] v, input logic [1:0] old);
        alpc_clip_len = (v <= {6'h00, ALPC_LEN_MAX}) ? v[1:0] : old;
    endfunction : alpc_clip_len

    wire async_mode = !link_s2_reg;
    wire wr_ok = ce_i && wr_i && async_mode;
    wire wr_hs1 = wr_ok && addr_i == ALPC_IDX_HS1;
    wire wr_hs2 = wr_ok && addr_i == ALPC_IDX_HS2;
    wire wr_elen = wr_ok && addr_i == ALPC_IDX_EOL_LEN;
    wire wr_eol1 = wr_ok && addr_i == ALPC_IDX_EOL1;
    wire wr_eol2 = wr_ok && addr_i == ALPC_IDX_EOL2;
    wire wr_plen = wr_ok && addr_i == ALPC_IDX_PR_LEN;
    wire wr_pr1 = wr_ok && addr_i == ALPC_IDX_PR1;
    wire wr_pr2 = wr_ok && addr_i == ALPC_IDX_PR2;
    wire wr_clen = wr_ok && addr_i == ALPC_IDX_CLEN;
    wire wr_stop = wr_ok && addr_i == ALPC_IDX_STOP;
    wire wr_par = ce_i && wr_i && addr_i == ALPC_IDX_PARITY;

    // ======================================================================
    // configuration registers
    logic [7:0] hs1_reg, hs2_reg, eol1_reg, eol2_reg, pr1_reg, pr2_reg;
    logic [1:0] elen_reg, plen_reg, clen_reg, stop_reg;
    logic [2:0] par_reg;
    logic [CNT_W-1:0] nak_cnt_reg;
    // load sequencer, one-hot: straps need two edges through the synchroniser
    // before they are trusted, so writes are dropped until RUN
    typedef enum logic [3:0] {
        ALPC_LD_W0 = 4'b0001,
        ALPC_LD_W1 = 4'b0010,
        ALPC_LD_W2 = 4'b0100,
        ALPC_LD_RUN = 4'b1000
    } alpc_load_t;
    alpc_load_t load_state_reg, load_state_next;
    always_comb begin
        case (load_state_reg)
            ALPC_LD_W0: load_state_next = ALPC_LD_W1;
            ALPC_LD_W1: load_state_next = ALPC_LD_W2;
            ALPC_LD_W2: load_state_next = ALPC_LD_RUN;
            ALPC_LD_RUN: load_state_next = ALPC_LD_RUN;
            default: load_state_next = ALPC_LD_W0; // a corrupt code restarts the wait
        endcase
    end
    wire load_sw = load_state_reg != ALPC_LD_RUN;
    wire load_now = load_state_reg == ALPC_LD_W2;

    // stop values 1, 1.5 and 2 accepted, others ignored
    wire stop_ok = wdata_i <= {6'h00, ALPC_STOP_2};
    wire slow_sw = baud_s2_reg <= 16'(ALPC_SLOW_BAUD);
    // 8-bit characters forbid forced parity; cannot store it then
    wire par_ok = wdata_i <= {5'h00, (clen_reg == ALPC_CLEN_8BIT) ? ALPC_PAR_MAX_8BIT
                                                                  : ALPC_PAR_MAX};

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            hs1_reg <= ALPC_RST_HS1;
            hs2_reg <= ALPC_RST_HS2;
            elen_reg <= ALPC_RST_EOL_LEN;
            eol1_reg <= ALPC_RST_EOL1;
            eol2_reg <= ALPC_RST_EOL2;
            plen_reg <= ALPC_RST_PR_LEN;
            pr1_reg <= ALPC_RST_PR1;
            pr2_reg <= ALPC_RST_PR2;
            clen_reg <= ALPC_RST_CLEN;
            stop_reg <= ALPC_STOP_1;
            par_reg <= ALPC_RST_PARITY;
            load_state_reg <= ALPC_LD_W0;
        end else if (ce_i) begin
            load_state_reg <= load_state_next;
            if (load_now) begin
                clen_reg <= clen_s2_reg;
                stop_reg <= slow_sw ? ALPC_STOP_2 : ALPC_STOP_1;
                par_reg <= par_s2_reg;
            end else if (!load_sw) begin
                if (wr_hs1) hs1_reg <= wdata_i;
                if (wr_hs2) hs2_reg <= wdata_i;
                if (wr_elen) elen_reg <= alpc_clip_len(wdata_i, elen_reg);
                if (wr_eol1) eol1_reg <= wdata_i;
                if (wr_eol2) eol2_reg <= wdata_i;
                if (wr_plen) plen_reg <= alpc_clip_len(wdata_i, plen_reg);
                if (wr_pr1) pr1_reg <= wdata_i;
                if (wr_pr2) pr2_reg <= wdata_i;
                if (wr_clen) clen_reg <= wdata_i[1:0];
                if (wr_stop && stop_ok) stop_reg <= wdata_i[1:0];
                if (wr_par && par_ok) par_reg <= wdata_i[2:0];
            end
        end
    end

    // ======================================================================
    // transmit error counter, saturating, cleared only by reset
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            nak_cnt_reg <= '0;
        end else if (ce_i && nak_rx_i && !(&nak_cnt_reg)) begin
            nak_cnt_reg <= nak_cnt_reg + 1'b1;
        end
    end

    // ======================================================================
    // end-of-line matcher: first char must be immediately followed by second
    logic got_first_reg, eol_reg;
    wire m1 = rx_valid_i && rx_char_i == eol1_reg;
    wire m2 = rx_valid_i && rx_char_i == eol2_reg;
    wire eol_next = async_mode && rx_valid_i &&
                    ((elen_reg == ALPC_LEN_ONE && m1) ||
                     (elen_reg == ALPC_LEN_MAX && got_first_reg && m2));
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            got_first_reg <= 1'b0;
            eol_reg <= 1'b0;
        end else if (ce_i) begin
            eol_reg <= eol_next;
            if (rx_valid_i) got_first_reg <= m1 && !eol_next;
        end
    end

    // ======================================================================
    // read mux, data one cycle after the strobe
    logic [7:0] rd_mux;
    always_comb begin
        rd_mux = ALPC_ZERO;
        case (addr_i)
            ALPC_IDX_HS1: rd_mux = link_s2_reg ? 8'(nak_cnt_reg) : hs1_reg;
            ALPC_IDX_PARITY: rd_mux = {5'h00, par_reg};
            default: begin
                if (async_mode) begin
                    case (addr_i)
                        ALPC_IDX_HS2: rd_mux = hs2_reg;
                        ALPC_IDX_EOL_LEN: rd_mux = {6'h00, elen_reg};
                        ALPC_IDX_EOL1: rd_mux = eol1_reg;
                        ALPC_IDX_EOL2: rd_mux = eol2_reg;
                        ALPC_IDX_PR_LEN: rd_mux = {6'h00, plen_reg};
                        ALPC_IDX_PR1: rd_mux = pr1_reg;
                        ALPC_IDX_PR2: rd_mux = pr2_reg;
                        ALPC_IDX_CLEN: rd_mux = {6'h00, clen_reg};
                        ALPC_IDX_STOP: rd_mux = {6'h00, stop_reg};
                        default: rd_mux = ALPC_ZERO;
                    endcase
                end
            end
        endcase
    end

    logic [7:0] rdata_reg;
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            rdata_reg <= ALPC_ZERO;
        end else if (ce_i) begin
            rdata_reg <= rd_i ? rd_mux : ALPC_ZERO;
        end
    end

    // ======================================================================
    // outputs; forced parity values are sent but never checked
    assign rdata_o = rdata_reg;
    assign hs1_o = hs1_reg;
    assign hs2_o = hs2_reg;
    assign data_bits_o = ALPC_BITS_MIN + {2'h0, clen_reg};
    assign stop_o = stop_reg;
    assign parity_o = par_reg;
    assign parity_check_o = par_reg == ALPC_PAR_ODD || par_reg == ALPC_PAR_EVEN;
    assign eol_o = eol_reg;

    // ======================================================================
    // checks
    chk_link_write_block: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        (ce_i && wr_i && link_s2_reg && addr_i == ALPC_IDX_HS2 && !load_sw)
        |=> $stable(hs2_reg)) else $error("write accepted in link mode");
    chk_nak_read: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        (ce_i && rd_i && addr_i == ALPC_IDX_HS1 && link_s2_reg)
        |=> rdata_o == $past(8'(nak_cnt_reg))) else $error("nak count read wrong");
    chk_hs1_read: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        (ce_i && rd_i && addr_i == ALPC_IDX_HS1 && !link_s2_reg)
        |=> rdata_o == $past(hs1_reg)) else $error("handshake read wrong");
    chk_reset_vals: assert property (@(posedge clk_sys_i)
        $past(rst_i) |-> hs1_reg == ALPC_RST_HS1 && hs2_reg == ALPC_RST_HS2 &&
        eol1_reg == ALPC_RST_EOL1 && pr2_reg == ALPC_RST_PR2) else $error("bad reset value");
    chk_len_range: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        elen_reg <= ALPC_LEN_MAX && plen_reg <= ALPC_LEN_MAX) else $error("length out of range");
    chk_stop_range: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        stop_reg <= ALPC_STOP_2) else $error("stop code out of range");
    chk_stop_default: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        (ce_i && load_now)
        |=> stop_reg == ($past(slow_sw) ? ALPC_STOP_2 : ALPC_STOP_1)) else $error("stop default");
    chk_clen_default: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        (ce_i && load_now)
        |=> clen_reg == $past(clen_s2_reg)) else $error("char length default");
    chk_eol_pair: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        (ce_i && async_mode && rx_valid_i && elen_reg == ALPC_LEN_MAX && got_first_reg &&
        rx_char_i == eol2_reg) |=> eol_o) else $error("eol pair missed");

    // ======================================================================
    // write path: an accepted write lands, a refused one leaves the value alone
    chk_hs1_write: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        (wr_hs1 && !load_sw)
        |=> hs1_o == $past(wdata_i)) else $error("first handshake write lost");
    chk_hs2_write: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        (wr_hs2 && !load_sw)
        |=> hs2_o == $past(wdata_i)) else $error("second handshake write lost");
    chk_eol1_write: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        (wr_eol1 && !load_sw)
        |=> eol1_reg == $past(wdata_i)) else $error("first eol char write lost");
    chk_eol2_write: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        (wr_eol2 && !load_sw)
        |=> eol2_reg == $past(wdata_i)) else $error("second eol char write lost");
    chk_pr1_write: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        (wr_pr1 && !load_sw)
        |=> pr1_reg == $past(wdata_i)) else $error("first prompt char write lost");
    chk_pr2_write: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        (wr_pr2 && !load_sw)
        |=> pr2_reg == $past(wdata_i)) else $error("second prompt char write lost");
    chk_clen_write: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        (wr_clen && !load_sw)
        |=> clen_reg == $past(wdata_i[1:0])) else $error("char length write lost");
    chk_elen_write: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        (wr_elen && !load_sw && wdata_i <= {6'h00, ALPC_LEN_MAX})
        |=> elen_reg == $past(wdata_i[1:0])) else $error("eol length write lost");
    chk_elen_refuse: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        (wr_elen && !load_sw && wdata_i > {6'h00, ALPC_LEN_MAX})
        |=> $stable(elen_reg)) else $error("eol length above two stored");
    chk_plen_write: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        (wr_plen && !load_sw && wdata_i <= {6'h00, ALPC_LEN_MAX})
        |=> plen_reg == $past(wdata_i[1:0])) else $error("prompt length write lost");
    chk_plen_refuse: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        (wr_plen && !load_sw && wdata_i > {6'h00, ALPC_LEN_MAX})
        |=> $stable(plen_reg)) else $error("prompt length above two stored");
    chk_stop_write: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        (wr_stop && !load_sw && wdata_i <= {6'h00, ALPC_STOP_2})
        |=> stop_o == $past(wdata_i[1:0])) else $error("stop write lost");
    chk_stop_refuse: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        (wr_stop && !load_sw && wdata_i > {6'h00, ALPC_STOP_2})
        |=> $stable(stop_reg)) else $error("bad stop code stored");
    chk_par_write: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        (wr_par && !load_sw && wdata_i <= {5'h00, ALPC_PAR_MAX_8BIT})
        |=> parity_o == $past(wdata_i[2:0])) else $error("parity write lost");
    chk_par_forced: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        (wr_par && !load_sw && clen_reg == ALPC_CLEN_8BIT && wdata_i > {5'h00, ALPC_PAR_MAX_8BIT})
        |=> $stable(par_reg)) else $error("forced parity stored with 8-bit chars");
    chk_link_write_all: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        (ce_i && wr_i && link_s2_reg && addr_i >= ALPC_IDX_HS1 && addr_i <= ALPC_IDX_STOP)
        |=> $stable(hs1_reg) && $stable(hs2_reg) && $stable(clen_reg)) else $error("link write");

    // ======================================================================
    // read path and setting outputs
    chk_link_hidden: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        (ce_i && rd_i && link_s2_reg && addr_i > ALPC_IDX_HS1 && addr_i <= ALPC_IDX_STOP)
        |=> rdata_o == ALPC_ZERO) else $error("async register visible in link mode");
    chk_echo_clen: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        (ce_i && rd_i && async_mode && addr_i == ALPC_IDX_CLEN)
        |=> rdata_o == {6'h00, $past(clen_reg)}) else $error("char length read wrong");
    chk_echo_stop: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        (ce_i && rd_i && async_mode && addr_i == ALPC_IDX_STOP)
        |=> rdata_o == {6'h00, $past(stop_reg)}) else $error("stop read wrong");
    chk_echo_plen: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        (ce_i && rd_i && async_mode && addr_i == ALPC_IDX_PR_LEN)
        |=> rdata_o == {6'h00, $past(plen_reg)}) else $error("prompt length read wrong");
    chk_read_idle: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        (ce_i && !rd_i)
        |=> rdata_o == ALPC_ZERO) else $error("read data outside its cycle");
    chk_bits_min: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        (clen_reg == '0)
        |-> data_bits_o == ALPC_BITS_MIN) else $error("shortest char length wrong");
    chk_bits_max: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        (clen_reg == ALPC_CLEN_8BIT)
        |-> data_bits_o == ALPC_BITS_MAX) else $error("longest char length wrong");
    chk_par_odd: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        (par_reg == ALPC_PAR_ODD)
        |-> parity_check_o) else $error("odd parity not checked");
    chk_par_nochk: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        (par_reg > ALPC_PAR_EVEN)
        |-> !parity_check_o) else $error("forced parity checked");

    // ======================================================================
    // error counter, delimiter, clock enable and the rest of the reset values
    chk_nak_step: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        (ce_i && nak_rx_i && !(&nak_cnt_reg))
        |=> nak_cnt_reg == $past(nak_cnt_reg) + 1'b1) else $error("nak not counted");
    chk_nak_hold: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        (!ce_i || !nak_rx_i)
        |=> $stable(nak_cnt_reg)) else $error("nak count moved without nak");
    chk_reset_rest: assert property (@(posedge clk_sys_i)
        $past(rst_i) |-> elen_reg == ALPC_RST_EOL_LEN && eol2_reg == ALPC_RST_EOL2 &&
        plen_reg == ALPC_RST_PR_LEN && pr1_reg == ALPC_RST_PR1) else $error("bad reset value");
    chk_eol_single: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        (ce_i && async_mode && rx_valid_i && elen_reg == ALPC_LEN_ONE && rx_char_i == eol1_reg)
        |=> eol_o) else $error("single eol char missed");
    chk_eol_broken: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        (ce_i && rx_valid_i && elen_reg == ALPC_LEN_MAX && !got_first_reg)
        |=> !eol_o) else $error("eol without first char");
    chk_eol_off: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        (ce_i && elen_reg == '0)
        |=> !eol_o) else $error("eol seen with delimiter off");
    chk_freeze: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        !ce_i |=> $stable(hs1_reg) && $stable(stop_reg) && $stable(nak_cnt_reg) &&
        $stable(rdata_o) && $stable(eol_o)) else $error("state moved with enable low");
endmodule : alpc_config
`default_nettype wire

// ### design/alpc_pkg.sv
`default_nettype none
// ==========================================================================
// shared constants for the async line protocol configuration block
package alpc_pkg;
    // register indices as numbered on the card; byte address is index
    localparam logic [7:0] ALPC_IDX_HS1 = 8'h1A;
    localparam logic [7:0] ALPC_IDX_HS2 = 8'h1B;
    localparam logic [7:0] ALPC_IDX_EOL_LEN = 8'h1C;
    localparam logic [7:0] ALPC_IDX_EOL1 = 8'h1D;
    localparam logic [7:0] ALPC_IDX_EOL2 = 8'h1E;
    localparam logic [7:0] ALPC_IDX_PR_LEN = 8'h1F;
    localparam logic [7:0] ALPC_IDX_PR1 = 8'h20;
    localparam logic [7:0] ALPC_IDX_PR2 = 8'h21;
    localparam logic [7:0] ALPC_IDX_CLEN = 8'h22;
    localparam logic [7:0] ALPC_IDX_STOP = 8'h23;
    localparam logic [7:0] ALPC_IDX_PARITY = 8'h24;
    // reset values
    localparam logic [7:0] ALPC_RST_HS1 = 8'h11;
    localparam logic [7:0] ALPC_RST_HS2 = 8'h13;
    localparam logic [1:0] ALPC_RST_EOL_LEN = 2'h2;
    localparam logic [7:0] ALPC_RST_EOL1 = 8'h0D;
    localparam logic [7:0] ALPC_RST_EOL2 = 8'h0A;
    localparam logic [1:0] ALPC_RST_PR_LEN = 2'h1;
    localparam logic [7:0] ALPC_RST_PR1 = 8'h11;
    localparam logic [7:0] ALPC_RST_PR2 = 8'h00;
    localparam logic [1:0] ALPC_RST_CLEN = 2'h3;
    localparam logic [2:0] ALPC_RST_PARITY = 3'h0;
    // limits on length style settings
    localparam logic [1:0] ALPC_LEN_MAX = 2'h2;
    localparam logic [1:0] ALPC_CLEN_8BIT = 2'h3;
    localparam logic [2:0] ALPC_PAR_MAX_8BIT = 3'h2;
    localparam logic [2:0] ALPC_PAR_MAX = 3'h4;
    localparam logic [1:0] ALPC_LEN_ONE = 2'h1;
    // parity codes that are really checked on receive
    localparam logic [2:0] ALPC_PAR_ODD = 3'h1;
    localparam logic [2:0] ALPC_PAR_EVEN = 3'h2;
    // data bits for the smallest and largest character length codes
    localparam logic [3:0] ALPC_BITS_MIN = 4'h5;
    localparam logic [3:0] ALPC_BITS_MAX = 4'h8;
    // stop bit codes
    localparam logic [1:0] ALPC_STOP_1 = 2'h0;
    localparam logic [1:0] ALPC_STOP_1P5 = 2'h1;
    localparam logic [1:0] ALPC_STOP_2 = 2'h2;
    // switch speed at or below which two stop bits are the default
    localparam int unsigned ALPC_SLOW_BAUD = 150;
    localparam logic [7:0] ALPC_ZERO = 8'h00;
endpackage : alpc_pkg
`default_nettype wire

// ### bench/alpc_remote_model.sv
`default_nettype none
// ==========================================================================
// far end of the serial line: hands received characters and naks upward
module alpc_remote_model (
    input wire logic clk_sys_i,
    output logic nak_rx_o,
    output logic rx_valid_o,
    output logic [7:0] rx_char_o
);
    timeunit 1ns;
    timeprecision 1ns;

    initial begin
        nak_rx_o = 1'b0;
        rx_valid_o = 1'b0;
        rx_char_o = 8'h55;
    end

    // one character, one cycle; idle data shows the inverse so stale values never match
    task automatic send_char(input logic [7:0] c);
        @(posedge clk_sys_i);
        rx_valid_o <= 1'b1;
        rx_char_o <= c;
        @(posedge clk_sys_i);
        rx_valid_o <= 1'b0;
        rx_char_o <= ~c;
    endtask : send_char

    // one negative acknowledgement from the remote host
    task automatic send_nak();
        @(posedge clk_sys_i);
        nak_rx_o <= 1'b1;
        @(posedge clk_sys_i);
        nak_rx_o <= 1'b0;
    endtask : send_nak
endmodule : alpc_remote_model
`default_nettype wire

// ### bench/test_alpc_config.sv
`default_nettype none
module test_alpc_config
    import alpc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

    logic clk_sys_i, rst_i, ce_i, wr_i, rd_i, link_mode_i;
    logic [7:0] addr_i, wdata_i, rdata_o, hs1_o, hs2_o, rx_char;
    logic [1:0] sw_clen_i, stop_o;
    logic [15:0] sw_baud_i;
    logic [2:0] sw_parity_i, parity_o;
    logic [3:0] data_bits_o;
    logic parity_check_o, eol_o, nak_rx, rx_valid;
    int n_mismatch = 0;
    int n_tests = 0;
    int n_eol = 0;
    int base;
    logic [7:0] lreg;
    logic [7:0] rst_tab [8] = '{8'h11, 8'h13, 8'h02, 8'h0D, 8'h0A, 8'h01, 8'h11, 8'h00};
    logic [7:0] par_w [5] = '{8'h03, 8'h01, 8'h04, 8'h05, 8'h00};
    logic [7:0] par_e [5] = '{8'h02, 8'h01, 8'h04, 8'h04, 8'h00};
    logic [7:0] pchk_e [5] = '{8'h01, 8'h01, 8'h00, 8'h00, 8'h00};

    alpc_config alpc_config_i (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .ce_i(ce_i),
        .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
        .link_mode_i(link_mode_i), .sw_clen_i(sw_clen_i), .sw_baud_i(sw_baud_i),
        .sw_parity_i(sw_parity_i), .nak_rx_i(nak_rx), .rx_valid_i(rx_valid),
        .rx_char_i(rx_char), .hs1_o(hs1_o), .hs2_o(hs2_o), .data_bits_o(data_bits_o),
        .stop_o(stop_o), .parity_o(parity_o), .parity_check_o(parity_check_o), .eol_o(eol_o));
    alpc_remote_model alpc_remote_model_i (.clk_sys_i(clk_sys_i), .nak_rx_o(nak_rx),
        .rx_valid_o(rx_valid), .rx_char_o(rx_char));

    // ======================================================================
    // clock, pulse counter, watchdog
    initial begin
        clk_sys_i = 1'b0;
        forever #50 clk_sys_i = ~clk_sys_i;
    end
    always @(posedge clk_sys_i) if (eol_o === 1'b1) n_eol <= n_eol + 1;
    // a hang counts as a mismatch and still ends through the verdict
    initial begin
        #5000000;
        n_mismatch++;
        print_verdict();
    end

    // ======================================================================
    // register port tasks and checks
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("ERROR t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge clk_sys_i);
        wr_i <= 1'b0;
    endtask : wr
    // read data stands only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk_sys_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge clk_sys_i);
        rd_i <= 1'b0;
        #1 chk(rdata_o, e);
    endtask : rd
    // straps are sampled after release, so they settle before reset ends
    task automatic do_reset(input logic [1:0] c, input logic [15:0] b, input logic [2:0] p);
        sw_clen_i <= c;
        sw_baud_i <= b;
        sw_parity_i <= p;
        rst_i <= 1'b1;
        repeat (6) @(posedge clk_sys_i);
        rst_i <= 1'b0;
        repeat (4) @(posedge clk_sys_i);
    endtask : do_reset
    task automatic set_link(input logic m);
        link_mode_i <= m;
        repeat (4) @(posedge clk_sys_i);
    endtask : set_link
    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : print_verdict

    // ======================================================================
    // main sequence
    initial begin
        rst_i = 1'b1;
        ce_i = 1'b1;
        {wr_i, rd_i, link_mode_i} = 3'h0;
        {addr_i, wdata_i} = 16'h0000;
        do_reset(2'h2, 16'd151, 3'h2);
        rd(ALPC_IDX_STOP, 8'h00);
        rd(ALPC_IDX_CLEN, 8'h02);
        rd(ALPC_IDX_PARITY, 8'h02);
        chk({4'h0, data_bits_o}, 8'h07);
        @(posedge clk_sys_i);
        do_reset(2'h1, 16'd150, 3'h2);
        for (int i = 0; i < 8; i++) begin
            rd(8'(8'h1A + i), rst_tab[i]);
        end
        rd(ALPC_IDX_CLEN, 8'h01);
        rd(ALPC_IDX_STOP, 8'h02);
        // lengths above two are refused and the old value stays
        for (int k = 0; k < 2; k++) begin
            lreg = (k == 0) ? ALPC_IDX_EOL_LEN : ALPC_IDX_PR_LEN;
            wr(lreg, 8'h01);
            wr(lreg, 8'h03);
            rd(lreg, 8'h01);
            wr(lreg, 8'h00);
            rd(lreg, 8'h00);
        end
        for (int v = 0; v < 4; v++) begin
            wr(ALPC_IDX_CLEN, 8'(v));
            rd(ALPC_IDX_CLEN, 8'(v));
            chk({4'h0, data_bits_o}, 8'(v + 5));
        end
        for (int v = 0; v < 4; v++) begin
            wr(ALPC_IDX_STOP, 8'(v));
            #1 chk({6'h0, stop_o}, (v < 3) ? 8'(v) : 8'h02);
        end
        rd(ALPC_IDX_STOP, 8'h02);
        // forced parity is refused while characters are 8 bits wide
        for (int i = 0; i < 5; i++) begin
            if (i == 2) wr(ALPC_IDX_CLEN, 8'h02);
            wr(ALPC_IDX_PARITY, par_w[i]);
            rd(ALPC_IDX_PARITY, par_e[i]);
            chk({5'h0, parity_o}, par_e[i]);
            chk({7'h0, parity_check_o}, pchk_e[i]);
        end
        wr(ALPC_IDX_HS1, 8'h06);
        wr(ALPC_IDX_HS2, 8'h05);
        #1 chk(hs1_o, 8'h06);
        chk(hs2_o, 8'h05);
        @(posedge clk_sys_i);
        ce_i <= 1'b0;
        wr(ALPC_IDX_HS2, 8'h13);
        ce_i <= 1'b1;
        rd(ALPC_IDX_HS2, 8'h05);
        rd(8'h40, 8'h00);
        @(posedge clk_sys_i);
        #1 chk(rdata_o, 8'h00);
        // delimiter detection: in order, consecutive, per length
        wr(ALPC_IDX_EOL_LEN, 8'h02);
        alpc_remote_model_i.send_char(8'h0D);
        alpc_remote_model_i.send_char(8'h0A);
        #1 chk({7'h0, eol_o}, 8'h01);
        // the pulse just checked is counted one edge later, so wait for it
        @(posedge clk_sys_i);
        #1 base = n_eol;
        alpc_remote_model_i.send_char(8'h0D);
        alpc_remote_model_i.send_char(8'h58);
        alpc_remote_model_i.send_char(8'h0A);
        alpc_remote_model_i.send_char(8'h0A);
        alpc_remote_model_i.send_char(8'h0D);
        wr(ALPC_IDX_EOL_LEN, 8'h01);
        wr(ALPC_IDX_EOL1, 8'h41);
        alpc_remote_model_i.send_char(8'h41);
        alpc_remote_model_i.send_char(8'h0D);
        wr(ALPC_IDX_EOL_LEN, 8'h00);
        alpc_remote_model_i.send_char(8'h41);
        repeat (3) @(posedge clk_sys_i);
        chk(8'(n_eol - base), 8'h01);
        // block link mode hides the async set except parity and shows the nak count
        repeat (3) alpc_remote_model_i.send_nak();
        set_link(1'b1);
        rd(ALPC_IDX_HS1, 8'h03);
        rd(ALPC_IDX_HS2, 8'h00);
        wr(ALPC_IDX_HS2, 8'h22);
        set_link(1'b0);
        rd(ALPC_IDX_HS2, 8'h05);
        rd(ALPC_IDX_HS1, 8'h06);
        print_verdict();
    end
endmodule : test_alpc_config
`default_nettype wire
